//--- dsl_pkg.sv
// Package holding constants and types of the serial DAC load interface
package dsl_pkg;
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned CODE_W       = 8;
    localparam int unsigned MODE_W       = 2;
    localparam int unsigned CNT_W        = 5;
    localparam int unsigned MODE_HI_POS  = 13;
    localparam int unsigned MODE_LO_POS  = 12;
    localparam int unsigned CODE_MSB_POS = 11;
    localparam int unsigned CODE_LSB_POS = 4;
    localparam logic [CNT_W-1:0]  BITS_PER_FRAME = 5'h10;
    localparam logic [CODE_W-1:0] CODE_RESET     = 8'h00;
    localparam logic [MODE_W-1:0] MODE_RESET     = 2'h0;
    localparam logic [WORD_W-1:0] SHIFT_RESET    = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_ZERO      = 8'h00;
    localparam logic [CODE_W-1:0] CODE_FULL      = 8'hFF;
    // Serial clock ceiling in kHz; the host must keep to it
    localparam int unsigned SCLK_MAX_KHZ = 30000;

    // Output mode encodings
    typedef enum logic [1:0] {
        DSL_MODE_NORMAL = 2'h0,
        DSL_MODE_PD_1K  = 2'h1,
        DSL_MODE_PD_100K = 2'h2,
        DSL_MODE_PD_TRI = 2'h3
    } dsl_mode_t;

    // Frame receiver states
    typedef enum logic [1:0] {
        DSL_ST_IDLE = 2'h0,
        DSL_ST_SHIFT = 2'h1,
        DSL_ST_DONE = 2'h2
    } dsl_state_t;
endpackage : dsl_pkg

//--- dsl_sync.sv
// Two-flop synchroniser for the three serial pins
`timescale 1ns/1ns
`default_nettype none
module dsl_sync
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] pins_in,
    output logic      [2:0] pins_out
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } dsl_sync_state_t;

    dsl_sync_state_t s_r;
    dsl_sync_state_t s_nxt;

    // First stage feeds only the second; idle level is frame-sync high
    always_comb
    begin
        s_nxt.meta   = pins_in;
        s_nxt.stable = s_r.meta;
        if (!reset_n)
        begin
            s_nxt.meta   = 3'h4;
            s_nxt.stable = 3'h4;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s_r <= s_nxt;
    end

    assign pins_out = s_r.stable;
endmodule // dsl_sync
`default_nettype wire

//--- dsl_serial_load.sv
// Serial write port and code register of an 8-bit voltage-output DAC
//
// Function
// R01 - A sixteen-bit shift register receives every write frame.
// R02 - Data is sampled on each falling serial-clock edge during a frame.
// R03 - Shifting is enabled only while the active-low frame sync is low.
// R04 - After the sixteenth falling edge the code and mode are updated.
// R05 - Frame sync rising before the sixteenth edge aborts with no update.
// R06 - The code is unsigned straight binary, 0 to 255, out = VDD*D/256.
// R07 - Code zero is zero scale and all-ones is full scale.
// R08 - The host keeps the serial clock at or below 30 MHz.
// R09 - Word is MSB first: two ignored, two mode, eight code, four ignored.
// R10 - Mode 00 normal, 01 1k to ground, 10 100k to ground, 11 three-state.
// R11 - Reset clears the code register until the first valid frame.
// R12 - Power-down leaves the stored code unchanged.
// R13 - Bit count restarts on frame-sync fall; extra edges are ignored.
`timescale 1ns/1ns
`default_nettype none
module dsl_serial_load
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      frame_sync_n,
    input  wire logic                      serial_clk,
    input  wire logic                      serial_din,
    output logic [dsl_pkg::CODE_W-1:0]     dac_code,
    output logic [dsl_pkg::MODE_W-1:0]     dac_mode,
    output logic                           power_down,
    output logic                           pd_1k_gnd,
    output logic                           pd_100k_gnd,
    output logic                           out_tristate,
    output logic                           load_pulse,
    output logic                           abort_pulse,
    output logic                           code_zero_scale,
    output logic                           code_full_scale
);
    typedef struct packed {
        dsl_pkg::dsl_state_t               st;
        logic [dsl_pkg::WORD_W-1:0]        shift;
        logic [dsl_pkg::CNT_W-1:0]         cnt;
        logic                              sclk_d;
        logic                              sync_d;
        logic [dsl_pkg::CODE_W-1:0]        code;
        logic [dsl_pkg::MODE_W-1:0]        mode;
        logic                              pd;
        logic                              pd1k;
        logic                              pd100k;
        logic                              tri_st;
        logic                              load;
        logic                              abort;
        logic                              zs;
        logic                              fs;
    } dsl_state_reg_t;

    dsl_state_reg_t s_r;
    dsl_state_reg_t s_nxt;
    logic [2:0]     pins_s;
    logic           sync_n_s;
    logic           sclk_s;
    logic           din_s;
    logic           sclk_fall;
    logic           sync_fall;
    logic           sync_rise;
    logic [dsl_pkg::WORD_W-1:0] word_in;

    // Pins come from another domain, so they pass two flops first
    dsl_sync u_sync
    (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .pins_in  ({frame_sync_n, serial_clk, serial_din}),
        .pins_out (pins_s)
    );

    assign sync_n_s  = pins_s[2];
    assign sclk_s    = pins_s[1];
    assign din_s     = pins_s[0];
    // Edge detection on synchronised copies only
    assign sclk_fall = s_r.sclk_d & ~sclk_s;       // see R02
    assign sync_fall = s_r.sync_d & ~sync_n_s;
    assign sync_rise = ~s_r.sync_d & sync_n_s;
    // MSB first: the newest bit enters at the bottom
    assign word_in   = {s_r.shift[dsl_pkg::WORD_W-2:0], din_s}; // see R09

    // Decode of the mode field into output-stage controls
    function automatic logic [3:0] mode_decode(input logic [1:0] m);
        case (m)
            dsl_pkg::DSL_MODE_NORMAL:  mode_decode = 4'h0;
            dsl_pkg::DSL_MODE_PD_1K:   mode_decode = 4'hC; // see R10
            dsl_pkg::DSL_MODE_PD_100K: mode_decode = 4'hA; // see R10
            dsl_pkg::DSL_MODE_PD_TRI:  mode_decode = 4'h9; // see R10
            default:                   mode_decode = 4'h0;
        endcase
    endfunction

    // Frame receiver and code register next state
    always_comb
    begin
        logic [dsl_pkg::CODE_W-1:0] c;
        logic [dsl_pkg::MODE_W-1:0] m;
        logic [3:0]                 d;
        c = s_r.code;
        m = s_r.mode;
        d = 4'h0;
        s_nxt        = s_r;
        s_nxt.sclk_d = sclk_s;
        s_nxt.sync_d = sync_n_s;
        s_nxt.load   = 1'b0;
        s_nxt.abort  = 1'b0;
        case (s_r.st)
            dsl_pkg::DSL_ST_IDLE:
            begin
                // A new frame only starts on a falling frame sync
                if (sync_fall)
                begin
                    s_nxt.st    = dsl_pkg::DSL_ST_SHIFT;  // see R03
                    s_nxt.cnt   = '0;                     // see R13
                    s_nxt.shift = dsl_pkg::SHIFT_RESET;
                end
            end
            dsl_pkg::DSL_ST_SHIFT:
            begin
                if (sync_n_s)
                begin
                    // Early rise: drop the partial word, keep code and mode
                    s_nxt.st    = dsl_pkg::DSL_ST_IDLE;   // see R05
                    s_nxt.shift = dsl_pkg::SHIFT_RESET;   // see R05
                    s_nxt.abort = 1'b1;                   // see R05
                end
                else if (sclk_fall)
                begin
                    s_nxt.shift = word_in;                // see R01
                    s_nxt.cnt   = s_r.cnt + 5'h01;
                    if (s_r.cnt == dsl_pkg::BITS_PER_FRAME - 5'h01)
                    begin
                        c = word_in[dsl_pkg::CODE_MSB_POS:
                                    dsl_pkg::CODE_LSB_POS];  // see R06
                        m = {word_in[dsl_pkg::MODE_HI_POS],
                             word_in[dsl_pkg::MODE_LO_POS]}; // see R09
                        s_nxt.code = c;                   // see R04
                        s_nxt.mode = m;                   // see R04
                        s_nxt.load = 1'b1;
                        s_nxt.st   = dsl_pkg::DSL_ST_DONE;
                    end
                end
            end
            dsl_pkg::DSL_ST_DONE:
            begin
                // Further clocks are ignored until frame sync goes high
                if (sync_n_s)
                begin
                    s_nxt.st = dsl_pkg::DSL_ST_IDLE;      // see R13
                end
            end
            default:
            begin
                s_nxt.st = dsl_pkg::DSL_ST_IDLE;
            end
        endcase
        // Power-down only changes the output stage, never the code
        d             = mode_decode(m);                   // see R12
        s_nxt.pd      = d[3];
        s_nxt.pd1k    = d[2];
        s_nxt.pd100k  = d[1];
        s_nxt.tri_st  = d[0];
        s_nxt.zs      = (c == dsl_pkg::CODE_ZERO);        // see R07
        s_nxt.fs      = (c == dsl_pkg::CODE_FULL);        // see R07
        if (!reset_n)
        begin
            s_nxt.st     = dsl_pkg::DSL_ST_IDLE;
            s_nxt.shift  = dsl_pkg::SHIFT_RESET;
            s_nxt.cnt    = '0;
            s_nxt.sclk_d = 1'b0;
            s_nxt.sync_d = 1'b1;
            s_nxt.code   = dsl_pkg::CODE_RESET;           // see R11
            s_nxt.mode   = dsl_pkg::MODE_RESET;
            s_nxt.pd     = 1'b0;
            s_nxt.pd1k   = 1'b0;
            s_nxt.pd100k = 1'b0;
            s_nxt.tri_st = 1'b0;
            s_nxt.load   = 1'b0;
            s_nxt.abort  = 1'b0;
            s_nxt.zs     = 1'b1;
            s_nxt.fs     = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s_r <= s_nxt;
    end

    // Outputs straight from the state flops
    assign dac_code        = s_r.code;
    assign dac_mode        = s_r.mode;
    assign power_down      = s_r.pd;
    assign pd_1k_gnd       = s_r.pd1k;
    assign pd_100k_gnd     = s_r.pd100k;
    assign out_tristate    = s_r.tri_st;
    assign load_pulse      = s_r.load;
    assign abort_pulse     = s_r.abort;
    assign code_zero_scale = s_r.zs;
    assign code_full_scale = s_r.fs;

    // Checks
    sequence s_last_edge;
        s_r.st == dsl_pkg::DSL_ST_SHIFT && !sync_n_s && sclk_fall
            && s_r.cnt == 5'h0F;
    endsequence

    property p_load_on_16;
        @(posedge ref_clk) disable iff (!reset_n)
        s_last_edge |=> load_pulse && dac_code == $past(word_in[11:4]);
    endproperty
    a_load_on_16: assert property (p_load_on_16) // see R04
        else $error("code not loaded on sixteenth edge");

    property p_abort_keeps;
        @(posedge ref_clk) disable iff (!reset_n)
        (s_r.st == dsl_pkg::DSL_ST_SHIFT && sync_n_s)
            |=> abort_pulse && $stable(dac_code) && $stable(dac_mode);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) // see R05
        else $error("early frame end changed code or mode");

    property p_no_load_idle;
        @(posedge ref_clk) disable iff (!reset_n)
        s_r.st != dsl_pkg::DSL_ST_SHIFT |=> !load_pulse ##0 $stable(dac_code);
    endproperty
    a_no_load_idle: assert property (p_no_load_idle) // see R13
        else $error("code changed outside a frame");

    property p_shift_in;
        @(posedge ref_clk) disable iff (!reset_n)
        (s_r.st == dsl_pkg::DSL_ST_SHIFT && !sync_n_s && sclk_fall)
            |=> s_r.shift[0] == $past(din_s);
    endproperty
    a_shift_in: assert property (p_shift_in) // see R02
        else $error("data bit not shifted in");

    property p_start;
        @(posedge ref_clk) disable iff (!reset_n)
        (s_r.st == dsl_pkg::DSL_ST_IDLE && sync_fall)
            |=> s_r.cnt == 5'h00 && s_r.st == dsl_pkg::DSL_ST_SHIFT;
    endproperty
    a_start: assert property (p_start) // see R03
        else $error("frame did not start on frame sync fall");

    property p_mode_map;
        @(posedge ref_clk) disable iff (!reset_n)
        load_pulse |=> power_down == (dac_mode != 2'h0)
            && pd_1k_gnd == (dac_mode == 2'h1)
            && pd_100k_gnd == (dac_mode == 2'h2)
            && out_tristate == (dac_mode == 2'h3);
    endproperty
    a_mode_map: assert property (p_mode_map) // see R10
        else $error("mode decode wrong");

    property p_pd_keeps_code;
        @(posedge ref_clk) disable iff (!reset_n)
        power_down && !load_pulse |-> $stable(dac_code);
    endproperty
    a_pd_keeps_code: assert property (p_pd_keeps_code) // see R12
        else $error("stored code lost");

    property p_reset_zero;
        @(posedge ref_clk)
        !reset_n |=> dac_code == 8'h00 && dac_mode == 2'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // see R11
        else $error("reset did not clear code");

    property p_full_flag;
        @(posedge ref_clk) disable iff (!reset_n)
        load_pulse |=> code_full_scale == (dac_code == 8'hFF);
    endproperty
    a_full_flag: assert property (p_full_flag) // see R07
        else $error("full-scale flag wrong");
endmodule // dsl_serial_load
`default_nettype wire

//--- dsl_host_model.sv
// Host serial port model that writes frames into the DAC load port
`timescale 1ns/1ns
`default_nettype none
module dsl_host_model
(
    input  wire logic        req,
    input  wire logic [15:0] word,
    input  wire logic [4:0]  n_edges,
    output logic             ack,
    output logic             frame_sync_n,
    output logic             serial_clk,
    output logic             serial_din
);
    int i;

    // Idle: sync high, clock parked high
    initial
    begin
        ack = 1'b0;
        frame_sync_n = 1'b1;
        serial_clk = 1'b1;
        serial_din = 1'b0;
    end

    // One frame per request; the 125 ns clock runs only inside a frame
    always
    begin
        wait (req);
        frame_sync_n = 1'b0;
        #63;
        for (i = 0; i < n_edges; i++)
        begin
            // Edges past the sixteenth carry filler that must be ignored
            serial_din = (i < 16) ? word[15 - i] : ~serial_din;
            #31 serial_clk = 1'b0; // 8 MHz, under the ceiling
            #62 serial_clk = 1'b1;
            #32;
        end
        // A released data line must not keep showing the last bit
        serial_din = ~serial_din;
        frame_sync_n = 1'b1;
        #63;
        ack = 1'b1;
        wait (!req);
        ack = 1'b0;
    end
endmodule // dsl_host_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the serial DAC load interface
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [7:0] CORNER [4] = '{8'h00, 8'hFF, 8'h7F, 8'h80};
    logic        ref_clk, reset_n, req, ack;
    logic        frame_sync_n, serial_clk, serial_din;
    logic [15:0] word;
    logic [4:0]  n_edges, n;
    logic [7:0]  dac_code, exp_code;
    logic [1:0]  dac_mode, exp_mode;
    logic        power_down, pd_1k_gnd, pd_100k_gnd, out_tristate;
    logic        load_pulse, abort_pulse, code_zero_scale, code_full_scale;
    logic [31:0] lfsr;
    int          n_errors, n_checks, n_loads, n_aborts;
    int          exp_loads, exp_aborts, k;

    dsl_serial_load dsl_serial_load_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .frame_sync_n(frame_sync_n),
        .serial_clk(serial_clk), .serial_din(serial_din),
        .dac_code(dac_code), .dac_mode(dac_mode), .power_down(power_down),
        .pd_1k_gnd(pd_1k_gnd), .pd_100k_gnd(pd_100k_gnd),
        .out_tristate(out_tristate), .load_pulse(load_pulse),
        .abort_pulse(abort_pulse), .code_zero_scale(code_zero_scale),
        .code_full_scale(code_full_scale));
    dsl_host_model dsl_host_model_inst (.req(req), .word(word),
        .n_edges(n_edges), .ack(ack), .frame_sync_n(frame_sync_n),
        .serial_clk(serial_clk), .serial_din(serial_din));

    // Free-running 250 MHz system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Count pulse cycles; a stretched pulse shows up as an extra count
    always @(negedge ref_clk)
    begin
        if (load_pulse === 1'b1) n_loads++;
        if (abort_pulse === 1'b1) n_aborts++;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected decodes and scale flags from mode and code
    function automatic logic [7:0] flags(input logic [1:0] m,
                                         input logic [7:0] c);
        return {2'h0, m != 2'h0, m == 2'h1, m == 2'h2, m == 2'h3,
                c == 8'h00, c == 8'hFF};
    endfunction

    task automatic chk_vec(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_state();
        chk_vec("code", exp_code, dac_code);
        chk_vec("mode", {6'h00, exp_mode}, {6'h00, dac_mode});
        chk_vec("decodes", flags(exp_mode, exp_code), {2'h0, power_down,
            pd_1k_gnd, pd_100k_gnd, out_tristate, code_zero_scale,
            code_full_scale});
        chk_vec("loads", exp_loads[7:0], n_loads[7:0]);
        chk_vec("aborts", exp_aborts[7:0], n_aborts[7:0]);
    endtask

    // Send one frame of n falling edges and check the result
    task automatic send(input logic [15:0] w, input logic [4:0] e);
        int t;
        @(negedge ref_clk);
        word = w;
        n_edges = e;
        req = 1'b1;
        t = 0;
        while (ack !== 1'b1 && t < 2000)
        begin
            @(negedge ref_clk);
            t++;
        end
        if (t >= 2000)
        begin
            n_errors++;
            tally_and_finish();
        end
        else
        begin
            req = 1'b0;
            if (e >= 5'h10)
            begin
                // Only the first sixteen bits count; the rest are ignored
                exp_code = w[11:4];
                exp_mode = w[13:12];
                exp_loads++;
            end
            else
                exp_aborts++;
            repeat (4) @(negedge ref_clk);
            check_state();
        end
    endtask

    // Main sequence: reset, aborts, every mode, corners, random frames
    initial
    begin
        reset_n = 1'b0;
        req = 1'b0;
        word = 16'h0000;
        n_edges = 5'h10;
        lfsr = 32'h00012006;
        {n_errors, n_checks, n_loads, n_aborts} = '0;
        {exp_loads, exp_aborts} = '0;
        exp_code = 8'h00;
        exp_mode = 2'h0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        check_state();
        send(16'h3FF0, 5'h0F);
        for (k = 0; k < 4; k++)
        begin
            lfsr = lfsr_next(lfsr);
            send({lfsr[15:14], k[1:0], CORNER[k], lfsr[3:0]}, 5'h10);
        end
        send(16'h0550, 5'h08);
        send(16'hC00F, 5'h1F);
        // Mid-run reset must clear code and mode again
        reset_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        exp_code = 8'h00;
        exp_mode = 2'h0;
        repeat (3) @(negedge ref_clk);
        check_state();
        for (k = 0; k < 14; k++)
        begin
            lfsr = lfsr_next(lfsr);
            case (lfsr[20:19])
                2'h0: n = {1'b0, lfsr[24:21]};
                2'h1: n = 5'h10 + {2'h0, lfsr[23:21]};
                default: n = 5'h10;
            endcase
            send(lfsr[15:0], n);
        end
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
